//--- board_model.sv
// Board side of port A: a driven pin shows the device level, else the board's.
// Assumes the board holds its own levels on every undriven pin.
`timescale 1ns/10ps
module board_model (
	input wire logic [6:0] pin_out,
	input wire logic [6:0] pin_oe,
	input wire logic [6:0] ext_level,
	output logic [6:0] pin_in
);
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

//--- port_a_axil_slave.sv
// AXI4-Lite slave front end: turns bus transfers into register strobes.
// Assumes the parent decodes wr_addr/rd_addr combinationally.
`timescale 1ns/10ps
module port_a_axil_slave
	import port_a_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_stb,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [7:0] wr_data,
	input wire logic wr_err,
	output logic [ADDR_W-1:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic rd_err
);
	logic aw_full_q;
	logic w_full_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0] wdata_q;
	logic lane0_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [7:0] rdata_q;
	wire aw_take = awvalid && awready;
	wire w_take = wvalid && wready;
	wire both_held = aw_full_q && w_full_q && !bvalid_q;
	wire ar_take = arvalid && arready;

	assign awready = !aw_full_q;
	assign wready = !w_full_q;
	assign arready = !rvalid_q;
	assign wr_stb = both_held && lane0_q;
	assign wr_addr = awaddr_q;
	assign wr_data = wdata_q;
	assign rd_addr = araddr;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = {24'h000000, rdata_q};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 8'h00;
			lane0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_full_q <= 1'b1;
				awaddr_q <= awaddr;
			end
			if (w_take) begin
				w_full_q <= 1'b1;
				wdata_q <= wdata[7:0];
				lane0_q <= wstrb[0];
			end
			if (both_held) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_err ? RESP_SLVERR : RESP_OKAY;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 8'h00;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rresp_q <= rd_err ? RESP_SLVERR : RESP_OKAY;
			rdata_q <= rd_err ? 8'h00 : rd_data;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
		end
	end
endmodule

//--- port_a_pin_function_mux.sv
// Port A pin function mux: seven shared pins, data/direction/function registers.
// Assumes pins and peripheral signals are synchronous to aclk; mode is stable.
//
// Overview of operation
// - Mode 4: clock/PWM enable blocks page address
// - Mode 4 low pins: direction picks page/input
// - Mode 4 pins 6,5: bus>serial>compare>port
// - Serial enable keeps compare off its pin
// - Mode 4 low: clock/PWM>page>input
// - Mode 7 peripheral pins ignore direction bit
// - Mode 7 pins 6,5: serial>compare>port
// - Mode 7 low: PWM/clock>compare>port
// - Mode 7: clock/PWM enable blocks compare
// - Input pin: write stored, read pin
// - Output pin: data drives, read register
// - Request/wait input: read pin level
// - Acknowledge output: read undefined value
// - Compare pin: read pin, write ignored
// - Page address pins: read undefined value
// - Transmit pin: write ignored, read pin
// - Direction bit one means output
// - Direction register reads all ones
`timescale 1ns/10ps
module port_a_pin_function_mux
	import port_a_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [2:0] op_mode,
	input wire logic bus_ctrl_en,
	input wire logic wait_en,
	input wire logic bus_ack_drive,
	input wire logic [3:0] page_addr,
	input wire logic serial_tx_out,
	input wire logic serial_clock_out,
	input wire logic serial_clock_oe,
	input wire logic pwm_out_a,
	input wire logic pwm_out_b,
	input wire logic pwm_out_c,
	input wire logic timer_c_compare_a,
	input wire logic timer_c_compare_b,
	input wire logic timer_d_compare_a,
	input wire logic timer_d_compare_b,
	input wire logic timer_e_compare_a,
	input wire logic timer_e_compare_b,
	input wire logic [6:0] compare_en,
	input wire logic [6:0] pin_in,
	output logic [6:0] pin_out,
	output logic [6:0] pin_oe,
	output logic serial_rx_in,
	output logic serial_clock_in,
	output logic bus_request_in,
	output logic wait_in
);
	logic [7:0] dir_q;
	logic [7:0] data_q;
	logic [7:0] port_function_ctrl;
	logic [6:0] pin_out_q;
	logic [6:0] pin_oe_q;
	logic wr_stb;
	logic [ADDR_W-1:0] wr_addr;
	logic [7:0] wr_data;
	logic [ADDR_W-1:0] rd_addr;
	logic [7:0] rd_data;
	logic [6:0] rd_port;
	pin_fn_t pin_fn [7];

	wire serial_tx_pin_en = port_function_ctrl[TX_EN_BIT];
	wire serial_rx_pin_en = port_function_ctrl[RX_EN_BIT];
	wire serial_clock_pin_en = port_function_ctrl[SCK_EN_BIT];
	wire pwm_out3_pin_en = port_function_ctrl[PW3_EN_BIT];
	wire pwm_out2_pin_en = port_function_ctrl[PW2_EN_BIT];
	wire pwm_out1_pin_en = port_function_ctrl[PW1_EN_BIT];

	wire mode_4 = (op_mode == MODE_4);
	wire mode_7 = (op_mode == MODE_7);
	wire mode_35 = (op_mode == MODE_3) || (op_mode == MODE_5);
	wire mode_1to6 = (op_mode != 3'h0) && !mode_7;
	wire bus_active = mode_1to6 && bus_ctrl_en;

	// Per-pin candidate functions, pins 6..0
	wire [6:0] periph_en = {serial_tx_pin_en, serial_rx_pin_en, 1'b0, serial_clock_pin_en,
		pwm_out3_pin_en, pwm_out2_pin_en, pwm_out1_pin_en};
	wire [6:0] periph_drv = {serial_tx_out, 1'b0, 1'b0, serial_clock_out,
		pwm_out_c, pwm_out_b, pwm_out_a};
	wire [6:0] periph_oe = {1'b1, 1'b0, 1'b0, serial_clock_oe, 3'b111};
	wire [6:0] compare_drv = {timer_c_compare_b, timer_c_compare_a, 1'b0,
		timer_e_compare_b, timer_e_compare_a, timer_d_compare_b, timer_d_compare_a};
	// Modes 3 and 5 let serial outrank bus control on pins 6 and 5
	wire [6:0] bus_sel = {bus_active && !(mode_35 && serial_tx_pin_en),
		bus_active && !(mode_35 && serial_rx_pin_en),
		mode_1to6 && wait_en, 4'b0000};
	wire page_low_ok = mode_35 || mode_4;
	wire compare_low_ok = !page_low_ok;

	// Function chosen for each pin, highest priority first
	for (genvar i = 0; i < 7; i++) begin : g_pin
		wire low = (i < 4);
		wire oc_ok = compare_en[i] && (low ? compare_low_ok : 1'b1);
		wire page_ok = low && (mode_35 || (mode_4 && dir_q[i]));
		always_comb begin
			if (bus_sel[i]) begin
				pin_fn[i] = (i == 6) ? FN_BUS_OUT : FN_BUS_IN;
			end else if (periph_en[i] && !(mode_35 && low)) begin
				pin_fn[i] = FN_PERIPH;
			end else if (page_ok) begin
				pin_fn[i] = FN_PAGE;
			end else if (oc_ok) begin
				pin_fn[i] = FN_COMPARE;
			end else if (dir_q[i] && !(mode_4 && low)) begin
				pin_fn[i] = FN_GP_OUT;
			end else begin
				pin_fn[i] = FN_GP_IN;
			end
		end

		// Pin drive; direction bit only matters for port functions and mode 4 page address pins
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pin_out_q[i] <= 1'b0;
				pin_oe_q[i] <= 1'b0;
			end else begin
				case (pin_fn[i])
					FN_BUS_OUT: begin
						pin_out_q[i] <= bus_ack_drive;
						pin_oe_q[i] <= 1'b1;
					end
					FN_PERIPH: begin
						pin_out_q[i] <= periph_drv[i];
						pin_oe_q[i] <= periph_oe[i];
					end
					FN_PAGE: begin
						pin_out_q[i] <= page_addr[i % 4];
						pin_oe_q[i] <= 1'b1;
					end
					FN_COMPARE: begin
						pin_out_q[i] <= compare_drv[i];
						pin_oe_q[i] <= 1'b1;
					end
					FN_GP_OUT: begin
						pin_out_q[i] <= data_q[i];
						pin_oe_q[i] <= 1'b1;
					end
					default: begin
						pin_out_q[i] <= 1'b0;
						pin_oe_q[i] <= 1'b0;
					end
				endcase
			end
		end

		// Data register read view of this pin
		always_comb begin
			case (pin_fn[i])
				FN_GP_OUT: rd_port[i] = data_q[i];
				FN_BUS_OUT: rd_port[i] = UNDEFINED_READ[i];
				FN_PAGE: rd_port[i] = UNDEFINED_READ[i];
				default: rd_port[i] = pin_in[i];
			endcase
		end
	end

	assign pin_out = pin_out_q;
	assign pin_oe = pin_oe_q;
	assign serial_rx_in = pin_in[5];
	assign bus_request_in = pin_in[5];
	assign wait_in = pin_in[4];
	assign serial_clock_in = pin_in[3];

	wire hit_dir_w = (wr_addr == DIR_OFFSET);
	wire hit_data_w = (wr_addr == DATA_OFFSET);
	wire hit_ctrl_w = (wr_addr == CTRL_OFFSET);
	wire wr_err = !(hit_dir_w || hit_data_w || hit_ctrl_w);
	wire hit_dir_r = (rd_addr == DIR_OFFSET);
	wire hit_data_r = (rd_addr == DATA_OFFSET);
	wire hit_ctrl_r = (rd_addr == CTRL_OFFSET);
	wire rd_err = !(hit_dir_r || hit_data_r || hit_ctrl_r);

	assign rd_data = hit_dir_r ? DIR_READ_VALUE :
		hit_data_r ? {data_q[7], rd_port} :
		hit_ctrl_r ? port_function_ctrl : 8'h00;

	// Data writes with wstrb[0] set always land in bits 6:0; the pin functions decide whether they show
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_q <= DIR_RESET;
			data_q <= DATA_RESET;
			port_function_ctrl <= CTRL_RESET;
		end else if (wr_stb) begin
			if (hit_dir_w) begin
				dir_q <= {DIR_RESET[7], wr_data[6:0]};
			end
			if (hit_data_w) begin
				data_q <= {DATA_RESET[7], wr_data[6:0]};
			end
			if (hit_ctrl_w) begin
				port_function_ctrl <= (wr_data & CTRL_WRITE_MASK) | CTRL_FIXED_ONES;
			end
		end
	end

	port_a_axil_slave u_slave (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);
endmodule

//--- port_a_pkg.sv
// Constants shared by the port A pin function mux and its register slave.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one register per word.
package port_a_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] DIR_OFFSET = 12'h000;
	localparam logic [11:0] DATA_OFFSET = 12'h004;
	localparam logic [11:0] CTRL_OFFSET = 12'h008;
	localparam logic [7:0] DIR_RESET = 8'h80;
	localparam logic [7:0] DATA_RESET = 8'h80;
	localparam logic [7:0] CTRL_RESET = 8'h90;
	localparam logic [7:0] DIR_READ_VALUE = 8'hff;
	localparam logic [7:0] CTRL_WRITE_MASK = 8'h6f;
	localparam logic [7:0] CTRL_FIXED_ONES = 8'h90;
	localparam logic [7:0] UNDEFINED_READ = 8'h00;
	localparam int unsigned TX_EN_BIT = 6;
	localparam int unsigned RX_EN_BIT = 5;
	localparam int unsigned SCK_EN_BIT = 3;
	localparam int unsigned PW3_EN_BIT = 2;
	localparam int unsigned PW2_EN_BIT = 1;
	localparam int unsigned PW1_EN_BIT = 0;
	localparam logic [2:0] MODE_3 = 3'h3;
	localparam logic [2:0] MODE_4 = 3'h4;
	localparam logic [2:0] MODE_5 = 3'h5;
	localparam logic [2:0] MODE_7 = 3'h7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		FN_GP_IN,
		FN_GP_OUT,
		FN_BUS_IN,
		FN_BUS_OUT,
		FN_PERIPH,
		FN_COMPARE,
		FN_PAGE
	} pin_fn_t;
endpackage

//--- port_a_props.sv
// Checker for the port A pin function mux, watching top-level ports only.
// Assumes pin_out/pin_oe lag their cause by one edge, as handed over.
`timescale 1ns/10ps
module port_a_props
	import port_a_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic [2:0] op_mode,
	input wire logic bus_ctrl_en,
	input wire logic wait_en,
	input wire logic bus_ack_drive,
	input wire logic [3:0] page_addr,
	input wire logic serial_tx_out,
	input wire logic pwm_out_a,
	input wire logic timer_c_compare_b,
	input wire logic timer_d_compare_a,
	input wire logic [6:0] compare_en,
	input wire logic [6:0] pin_in,
	input wire logic [6:0] pin_out,
	input wire logic [6:0] pin_oe,
	input wire logic bus_request_in,
	input wire logic wait_in
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire ar_hs = arvalid && arready;
	AST_ACK_M4: assert property (op_mode == MODE_4 && bus_ctrl_en |=> pin_oe[6] && !pin_oe[5]
		&& pin_out[6] == $past(bus_ack_drive)) else $error("acknowledge pin wrong");
	AST_ACK_READ: assert property (ar_hs && araddr == DATA_OFFSET && op_mode == MODE_4
		&& bus_ctrl_en |=> rvalid && rdata[6] == 1'b0) else $error("acknowledge read wrong");
	AST_WAIT_IN: assert property (wait_en && op_mode != MODE_7 |=> !pin_oe[4])
		else $error("wait pin driven");
	AST_REQ_LEVEL: assert property (bus_request_in == pin_in[5] && wait_in == pin_in[4])
		else $error("request level wrong");
	AST_M4_LOW: assert property (op_mode == MODE_4 |=> !pin_oe[0] || pin_out[0] == $past(pwm_out_a)
		|| pin_out[0] == $past(page_addr[0])) else $error("mode 4 low pin wrong");
	AST_M3_PAGE: assert property (op_mode == MODE_3 |=> pin_oe[3:0] == 4'hf
		&& pin_out[3:0] == $past(page_addr)) else $error("page address wrong");
	AST_DIR_READ: assert property (ar_hs && araddr == DIR_OFFSET |=> rvalid
		&& rdata == 32'h000000ff) else $error("direction read wrong");
	AST_M7_PIN6: assert property (op_mode == MODE_7 && compare_en[6] |=> pin_oe[6]
		&& (pin_out[6] == $past(serial_tx_out) || pin_out[6] == $past(timer_c_compare_b)))
		else $error("mode 7 pin 6 wrong");
	AST_M7_PIN0: assert property (op_mode == MODE_7 && compare_en[0] |=> pin_oe[0]
		&& (pin_out[0] == $past(pwm_out_a) || pin_out[0] == $past(timer_d_compare_a)))
		else $error("mode 7 pin 0 wrong");
	CV_READ: cover property (ar_hs);
	CV_BUS: cover property (op_mode == MODE_4 && bus_ctrl_en);
	CV_CMP: cover property (op_mode == MODE_7 && compare_en[6]);
endmodule
bind port_a_pin_function_mux port_a_props i_props(.aclk, .aresetn, .araddr, .arvalid, .arready,
	.rdata, .rvalid, .op_mode, .bus_ctrl_en, .wait_en, .bus_ack_drive, .page_addr, .serial_tx_out,
	.pwm_out_a, .timer_c_compare_b, .timer_d_compare_a, .compare_en, .pin_in, .pin_out, .pin_oe,
	.bus_request_in, .wait_in);

//--- testbench.sv
// Self-checking bench for the port A pin function mux over AXI4-Lite.
// Assumes the board model and the props checker are compiled alongside.
`timescale 1ns/10ps
module testbench;
	import port_a_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
	logic arready, rvalid, bus_ctrl_en, wait_en, bus_ack_drive, serial_tx_out, serial_clock_out;
	logic serial_clock_oe, pwm_out_a, pwm_out_b, pwm_out_c, timer_c_compare_a, timer_c_compare_b;
	logic timer_d_compare_a, timer_d_compare_b, timer_e_compare_a, timer_e_compare_b;
	logic serial_rx_in, serial_clock_in, bus_request_in, wait_in;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, page_addr;
	logic [1:0] bresp, rresp;
	logic [2:0] op_mode;
	logic [6:0] compare_en, ext_level, pin_in, pin_out, pin_oe;
	logic [7:0] rv;
	int n_fail = 0;
	int samples_checked = 0;
	port_a_pin_function_mux i_port_a_pin_function_mux(.*);
	board_model i_board_model(.pin_out, .pin_oe, .ext_level, .pin_in);
	initial begin
		aclk = 0;
		forever #12.5 aclk = ~aclk;
	end
	task automatic end_of_test();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		chk({6'h0, bresp}, {6'h0, RESP_OKAY});
		bready <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rv = rdata[7:0];
		chk({6'h0, rresp}, {6'h0, er});
		chk(rv, e);
		rready <= 1'b0;
	endtask
	task automatic pins(input logic [6:0] oe, input logic [6:0] o);
		repeat (3) @(posedge aclk);
		#1;
		chk({1'b0, pin_oe}, {1'b0, oe});
		chk({1'b0, pin_out & oe}, {1'b0, o & oe});
	endtask
	task automatic rst_to(input logic [2:0] m);
		@(posedge aclk);
		op_mode <= m;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	initial begin
		repeat (4000) @(posedge aclk);
		n_fail++;
		end_of_test();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, bus_ctrl_en, wait_en} = '0;
		{bus_ack_drive, serial_tx_out, serial_clock_out, serial_clock_oe} = '0;
		{pwm_out_a, pwm_out_b, pwm_out_c, timer_c_compare_a, timer_c_compare_b} = '0;
		{timer_d_compare_a, timer_d_compare_b, timer_e_compare_a, timer_e_compare_b} = '0;
		{awaddr, araddr, wdata, page_addr, compare_en, ext_level} = '0;
		wstrb = 4'hf;
		op_mode = MODE_7;
		rst_to(MODE_7);
		rdc(DIR_OFFSET, 8'hff, RESP_OKAY);
		rdc(CTRL_OFFSET, 8'h90, RESP_OKAY);
		rdc(DATA_OFFSET, 8'h80, RESP_OKAY);
		rdc(12'h00c, 8'h00, RESP_SLVERR);
		wr(DIR_OFFSET, 8'h7f);
		wr(DATA_OFFSET, 8'h55);
		pins(7'h7f, 7'h55);
		rdc(DATA_OFFSET, 8'hd5, RESP_OKAY);
		rdc(DIR_OFFSET, 8'hff, RESP_OKAY);
		wr(DIR_OFFSET, 8'h00);
		ext_level <= 7'h2a;
		wr(DATA_OFFSET, 8'h00);
		pins(7'h00, 7'h00);
		chk({4'h0, serial_rx_in, serial_clock_in, bus_request_in, wait_in}, 8'h0e);
		rdc(DATA_OFFSET, 8'haa, RESP_OKAY);
		compare_en <= 7'h6f;
		{timer_c_compare_b, timer_e_compare_b, timer_d_compare_b, timer_d_compare_a} <= 4'hf;
		pins(7'h6f, 7'h4b);
		wr(DATA_OFFSET, 8'h00);
		rdc(DATA_OFFSET, 8'hcb, RESP_OKAY);
		serial_clock_oe <= 1'b1;
		pwm_out_c <= 1'b1;
		wr(CTRL_OFFSET, 8'h6f);
		pins(7'h4f, 7'h04);
		rdc(CTRL_OFFSET, 8'hff, RESP_OKAY);
		rdc(DATA_OFFSET, 8'ha4, RESP_OKAY);
		rst_to(MODE_4);
		page_addr <= 4'ha;
		wr(DIR_OFFSET, 8'h0f);
		pins(7'h6f, 7'h4a);
		rdc(DATA_OFFSET, 8'hc0, RESP_OKAY);
		wr(DIR_OFFSET, 8'h00);
		pins(7'h60, 7'h40);
		rdc(DATA_OFFSET, 8'hca, RESP_OKAY);
		wr(DIR_OFFSET, 8'h0f);
		wr(CTRL_OFFSET, 8'h0f);
		pins(7'h6f, 7'h44);
		bus_ctrl_en <= 1'b1;
		wait_en <= 1'b1;
		wr(CTRL_OFFSET, 8'h6f);
		pins(7'h4f, 7'h04);
		rdc(DATA_OFFSET, 8'ha4, RESP_OKAY);
		bus_ctrl_en <= 1'b0;
		wait_en <= 1'b0;
		rst_to(MODE_3);
		pins(7'h6f, 7'h4a);
		rdc(DATA_OFFSET, 8'hc0, RESP_OKAY);
		end_of_test();
	end
endmodule
